// *** ufc_pkg.sv ***
// package: constants and types for the uart flow, interrupt and dma control
package ufc_pkg;
    localparam logic [7:0] UFC_LCR_RESET   = 8'h1d;
    localparam logic [7:0] UFC_LSR_RESET   = 8'h60;
    localparam logic [5:0] UFC_ID_NONE     = 6'h01;
    localparam logic [5:0] UFC_ID_LINE     = 6'h06;
    localparam logic [5:0] UFC_ID_TMO      = 6'h0c;
    localparam logic [5:0] UFC_ID_RXD      = 6'h04;
    localparam logic [5:0] UFC_ID_THR      = 6'h02;
    localparam logic [5:0] UFC_ID_MODEM    = 6'h00;
    localparam logic [5:0] UFC_ID_PAUSE    = 6'h10;
    localparam logic [5:0] UFC_ID_FLOWPIN  = 6'h20;
    localparam int         UFC_IE_RXD      = 0;
    localparam int         UFC_IE_THR      = 1;
    localparam int         UFC_IE_LINE     = 2;
    localparam int         UFC_IE_MODEM    = 3;
    localparam int         UFC_IE_PAUSE    = 5;
    localparam int         UFC_IE_FLOWPIN  = 7;
    localparam int         UFC_EF_SPECIAL  = 5;
    localparam int         UFC_FC_ENABLE   = 0;
    localparam int         UFC_FC_DMA      = 3;
    localparam int         UFC_LS_RX_DATA_AVAIL     = 0;
    localparam int         UFC_LS_OE       = 1;
    localparam int         UFC_LS_THRE     = 5;
    localparam int         UFC_LS_TEMT     = 6;
    localparam int         UFC_LS_FIFOERR  = 7;

    // error flags stored with each received character
    typedef struct packed {
        logic brk;
        logic frm;
        logic par;
    } ufc_err_type;

    // pause/resume character set, kept across reset
    typedef struct packed {
        logic [7:0] resume_a;
        logic [7:0] resume_b;
        logic [7:0] pause_a;
        logic [7:0] pause_b;
    } ufc_chars_type;

    typedef enum logic [3:0] {
        UFC_TX_IDLE  = 4'b0001,
        UFC_TX_DATA  = 4'b0010,
        UFC_TX_FLOW1 = 4'b0100,
        UFC_TX_FLOW2 = 4'b1000
    } ufc_txs_type;
endpackage : ufc_pkg

// *** ufc_ctrl.sv ***
// module: one-channel uart flow control, interrupt and dma control logic
`timescale 1ns/1ps
// Overview of operation
// - pause received halts tx after current char
// - pause detection sets pause id when enabled
// - resume restarts tx; special pause clears on read
// - send pause once rx level passes halt
// - send resume when rx level falls to resume
// - flow chars framed like data, low bits
// - line control resets to 1d
// - ident resets to 01, line status 60
// - modem change flags clear, upper zero, then follow pins
// - divisors, scratchpad, flow chars not reset
// - reset drives tx, rts, dtr, rx_dma_ready_n high
// - seven gated interrupt types, six-bit code
// - fixed identification codes per type
// - line irq clears on errors read, overrun
// - rx irqs clear on read; thr on ident/write
// - rts/cts rising raises irq, ident read clears
// - fifo error bit tracks errored characters
// - per-char errors show head, zero when empty
// - low enables set means interrupt mode
// - fifo control bit picks dma mode
// - single mode tx ready empty-holding only
// - flow field selects tx pairs, rx compare
// - special char sets irq, no halt, stored
// - single mode rx ready while data held
module ufc_ctrl #(
    parameter int DEPTH = 64,
    parameter int LW    = 7
) (
    input  wire logic                   clk_sys,
    input  wire logic                   reset,
    input  wire logic [7:0]             irq_enable_reg,
    input  wire logic [7:0]             fifo_control_reg,
    input  wire logic [7:0]             enhanced_feature_reg,
    input  wire logic [7:0]             flow_threshold_reg,
    input  wire logic [1:0]             word_len,
    input  wire ufc_pkg::ufc_chars_type chars_in,
    input  wire logic                   chars_we,
    input  wire logic [7:0]             scratch_in,
    input  wire logic                   scratch_we,
    input  wire logic [15:0]            divisor_in,
    input  wire logic                   divisor_we,
    input  wire logic                   rx_valid,
    input  wire logic [7:0]             rx_char,
    input  wire ufc_pkg::ufc_err_type   rx_err,
    input  wire logic                   rx_overrun,
    input  wire logic                   rx_timeout,
    input  wire logic [LW-1:0]          rx_level,
    input  wire logic                   rx_above_trig,
    input  wire logic                   rx_pop,
    input  wire ufc_pkg::ufc_err_type   rx_head_err,
    input  wire logic [LW-1:0]          rx_err_count,
    input  wire logic                   tx_empty,
    input  wire logic                   tx_trig,
    input  wire logic                   tx_write,
    input  wire logic                   shifter_busy,
    input  wire logic                   shifter_done,
    input  wire logic [3:0]             modem_pins,
    input  wire logic                   cts_pin,
    input  wire logic                   rts_pin,
    input  wire logic                   ident_read,
    input  wire logic                   lsr_read,
    input  wire logic                   msr_read,
    output logic                        tx_allow,
    output logic                        flow_load,
    output logic [7:0]                  flow_char,
    output logic [7:0]                  line_control_reg,
    output logic [7:0]                  line_status_reg,
    output logic [7:0]                  modem_status_reg,
    output logic [7:0]                  irq_ident_reg,
    output logic                        irq_out,
    output logic [7:0]                  scratchpad_reg,
    output logic [15:0]                 divisor_out,
    output ufc_pkg::ufc_chars_type      chars_out,
    output logic                        ser_out_idle,
    output logic                        rts_n,
    output logic                        dtr_n,
    output logic                        rx_dma_ready_n,
    output logic                        tx_dma_ready_n
);
    import ufc_pkg::*;
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic          halted, pause_flow, pause_spec, half_pause;
        logic          half_resume, sent_pause, need_pause, need_resume;
        ufc_txs_type   txs;
        logic [7:0]    fchar;
        logic          fload, overrun, thr_irq, flowpin_irq, tx_held;
        logic [3:0]    delta, pins_q, pins_s1, pins_s2;
        logic [1:0]    fpin_s1, fpin_s2, fpin_q;
        logic [1:0]    warm;
    } ufc_state_type;
    ufc_state_type s_q, s_d;
    ufc_chars_type chars_q;
    logic [7:0]    spr_q;
    logic [15:0]   div_q;
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] frame_mask(input logic [1:0] wl);
        frame_mask = 8'hff >> (2'd3 - wl);
    endfunction : frame_mask
    function automatic logic [LW-1:0] lvl(input logic [3:0] nib);
        lvl = LW'(nib) << 2;
    endfunction : lvl
    logic [1:0] rxsel, txsel;
    logic       fifo_on, mode_block, line_src, rxd_src, tmo_src;
    logic       thr_src, mod_src, pz_src, fp_src;
    logic       m_pa, m_pb, m_ra, m_rb, any_pause, any_resume;
    logic [5:0] id_code;
    logic [7:0] msk;
    assign rxsel      = enhanced_feature_reg[1:0];
    assign txsel      = enhanced_feature_reg[3:2];
    assign fifo_on    = fifo_control_reg[UFC_FC_ENABLE];
    assign mode_block = fifo_on & fifo_control_reg[UFC_FC_DMA];
    assign msk        = frame_mask(word_len);
    assign m_pa = rx_valid & (rx_char == chars_q.pause_a);
    assign m_pb = rx_valid & (rx_char == chars_q.pause_b);
    assign m_ra = rx_valid & (rx_char == chars_q.resume_a);
    assign m_rb = rx_valid & (rx_char == chars_q.resume_b);
    // ****************************************
    // receive compare and transmit flow
    // ****************************************
    always_comb begin
        s_d        = s_q;
        s_d.fload  = 1'b0;
        any_pause  = 1'b0;
        any_resume = 1'b0;
        case (rxsel)
            2'b10: begin
                any_pause  = m_pa;
                any_resume = m_ra;
            end
            2'b01: begin
                any_pause  = m_pb;
                any_resume = m_rb;
            end
            2'b11: begin
                if (txsel == 2'b11 || txsel == 2'b00) begin
                    any_pause  = s_q.half_pause & m_pb;
                    any_resume = s_q.half_resume & m_rb;
                    s_d.half_pause  = rx_valid ? m_pa : s_q.half_pause;
                    s_d.half_resume = rx_valid ? m_ra : s_q.half_resume;
                end else begin
                    any_pause  = m_pa | m_pb;
                    any_resume = m_ra | m_rb;
                end
            end
            default: any_pause = 1'b0;
        endcase
        if (any_pause) begin
            s_d.halted     = 1'b1;
            s_d.pause_flow = 1'b1;
        end
        if (any_resume) begin
            s_d.halted     = 1'b0;
            s_d.pause_flow = 1'b0;
            s_d.pause_spec = 1'b0;
        end
        // special char: flag only, data still stored downstream
        if (enhanced_feature_reg[UFC_EF_SPECIAL] && m_pb) begin
            s_d.pause_spec = 1'b1;
        end else if (ident_read) begin
            s_d.pause_spec = 1'b0;
        end
        // threshold driven pause / resume requests
        if (txsel != 2'b00 && !s_q.sent_pause &&
            rx_level > lvl(flow_threshold_reg[3:0])) begin
            s_d.need_pause = 1'b1;
            s_d.sent_pause = 1'b1;
        end
        if (txsel != 2'b00 && s_q.sent_pause &&
            rx_level <= lvl(flow_threshold_reg[7:4])) begin
            s_d.need_resume = 1'b1;
            s_d.sent_pause  = 1'b0;
        end
        case (s_q.txs)
            UFC_TX_IDLE: begin
                if (!shifter_busy && (s_q.need_pause || s_q.need_resume)) begin
                    s_d.fchar = (s_q.need_pause ?
                        (txsel[1] ? chars_q.pause_a : chars_q.pause_b) :
                        (txsel[1] ? chars_q.resume_a : chars_q.resume_b))
                        & msk;
                    s_d.fload = 1'b1;
                    s_d.txs   = (txsel == 2'b11) ? UFC_TX_FLOW1 : UFC_TX_FLOW2;
                end else if (!shifter_busy && !s_q.halted && !tx_empty) begin
                    s_d.txs = UFC_TX_DATA;
                end
            end
            UFC_TX_DATA: begin
                if (shifter_done) s_d.txs = UFC_TX_IDLE;
            end
            UFC_TX_FLOW1: begin
                if (shifter_done) begin
                    s_d.fchar = (s_q.need_pause ? chars_q.pause_b :
                        chars_q.resume_b) & msk;
                    s_d.fload = 1'b1;
                    s_d.txs   = UFC_TX_FLOW2;
                end
            end
            UFC_TX_FLOW2: begin
                if (shifter_done) begin
                    if (s_q.need_pause) s_d.need_pause = 1'b0;
                    else s_d.need_resume = 1'b0;
                    s_d.txs = UFC_TX_IDLE;
                end
            end
            default: s_d.txs = UFC_TX_IDLE;
        endcase
        // line status: overrun set wins over read
        if (rx_overrun) s_d.overrun = 1'b1;
        else if (lsr_read) s_d.overrun = 1'b0;
        // transmit empty interrupt, set wins
        if (tx_write || ident_read) s_d.thr_irq = 1'b0;
        if ((fifo_on ? tx_trig : tx_empty) && !s_q.tx_held)
            s_d.thr_irq = 1'b1;
        s_d.tx_held = fifo_on ? tx_trig : tx_empty;
        // modem inputs synchronised, change flags
        s_d.pins_s1 = modem_pins;
        s_d.pins_s2 = s_q.pins_s1;
        s_d.pins_q  = s_q.pins_s2;
        if (msr_read) s_d.delta = 4'h0;
        if (!(&s_q.warm)) s_d.warm = s_q.warm + 2'd1;
        if (&s_q.warm)
            s_d.delta = s_d.delta | (s_q.pins_s2 ^ s_q.pins_q);
        // flow pin rising edge, set wins over ident read
        s_d.fpin_s1 = {cts_pin, rts_pin};
        s_d.fpin_s2 = s_q.fpin_s1;
        s_d.fpin_q  = s_q.fpin_s2;
        if (ident_read) s_d.flowpin_irq = 1'b0;
        if (&s_q.warm && |(s_q.fpin_s2 & ~s_q.fpin_q))
            s_d.flowpin_irq = 1'b1;
    end
    // ****************************************
    // interrupt priority
    // ****************************************
    assign line_src = irq_enable_reg[UFC_IE_LINE] &
                      (s_q.overrun | (rx_err_count != '0));
    assign tmo_src  = irq_enable_reg[UFC_IE_RXD] & rx_timeout;
    assign rxd_src  = irq_enable_reg[UFC_IE_RXD] &
                      (fifo_on ? rx_above_trig : (rx_level != '0));
    assign thr_src  = irq_enable_reg[UFC_IE_THR] & s_q.thr_irq;
    assign mod_src  = irq_enable_reg[UFC_IE_MODEM] & (s_q.delta != 4'h0);
    assign pz_src   = irq_enable_reg[UFC_IE_PAUSE] &
                      (s_q.pause_flow | s_q.pause_spec);
    assign fp_src   = irq_enable_reg[UFC_IE_FLOWPIN] & s_q.flowpin_irq;
    always_comb begin
        if (line_src)     id_code = UFC_ID_LINE;
        else if (tmo_src) id_code = UFC_ID_TMO;
        else if (rxd_src) id_code = UFC_ID_RXD;
        else if (thr_src) id_code = UFC_ID_THR;
        else if (mod_src) id_code = UFC_ID_MODEM;
        else if (pz_src)  id_code = UFC_ID_PAUSE;
        else if (fp_src)  id_code = UFC_ID_FLOWPIN;
        else              id_code = UFC_ID_NONE;
    end
    assign irq_ident_reg = {2'b00, id_code};
    assign irq_out = (id_code != UFC_ID_NONE);
    // ****************************************
    // status and dma outputs
    // ****************************************
    assign line_status_reg = {(rx_err_count != '0),
                              tx_empty & ~shifter_busy, tx_empty,
                              (rx_level != '0) ? rx_head_err : 3'b000,
                              s_q.overrun, (rx_level != '0)};
    assign modem_status_reg = {s_q.pins_q, s_q.delta};
    assign line_control_reg = UFC_LCR_RESET;
    assign tx_allow   = (s_q.txs == UFC_TX_DATA);
    assign flow_load  = s_q.fload;
    assign flow_char  = s_q.fchar;
    assign ser_out_idle = 1'b1;
    assign rts_n      = 1'b1;
    assign dtr_n      = 1'b1;
    assign rx_dma_ready_n = reset ? 1'b1 : (mode_block ?
        !(rx_above_trig | rx_timeout) : (rx_level == '0));
    assign tx_dma_ready_n = reset ? 1'b0 : (mode_block ?
        !tx_trig : !tx_empty);
    assign scratchpad_reg = spr_q;
    assign divisor_out    = div_q;
    assign chars_out      = chars_q;
    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s_q     <= '0;
            s_q.txs <= UFC_TX_IDLE;
        end else begin
            s_q <= s_d;
        end
    end
    // no reset on these
    always_ff @(posedge clk_sys) begin
        if (chars_we) chars_q <= chars_in;
        if (scratch_we) spr_q <= scratch_in;
        if (divisor_we) div_q <= divisor_in;
    end
    // ****************************************
    // checks
    // ****************************************
    property p_pause_halts;
        @(posedge clk_sys) disable iff (reset)
        (any_pause && !any_resume) |=> s_q.halted;
    endproperty
    a_pause_halts: assert property (p_pause_halts)
        else $error("pause did not halt");
    property p_halt_no_start;
        @(posedge clk_sys) disable iff (reset)
        (s_q.halted && s_q.txs == UFC_TX_IDLE) |=> s_q.txs != UFC_TX_DATA;
    endproperty
    a_halt_no_start: assert property (p_halt_no_start)
        else $error("data started while halted");
    property p_pause_id;
        @(posedge clk_sys) disable iff (reset)
        (s_q.pause_flow && irq_enable_reg[UFC_IE_PAUSE] && !line_src &&
         !tmo_src && !rxd_src && !thr_src && !mod_src)
        |-> irq_ident_reg[5:0] == UFC_ID_PAUSE && irq_out;
    endproperty
    a_pause_id: assert property (p_pause_id)
        else $error("pause id missing");
    property p_resume_clears;
        @(posedge clk_sys) disable iff (reset)
        any_resume |=> !s_q.pause_flow && !s_q.halted;
    endproperty
    a_resume_clears: assert property (p_resume_clears)
        else $error("resume did not clear");
    property p_line_first;
        @(posedge clk_sys) disable iff (reset)
        line_src |-> irq_ident_reg[5:0] == UFC_ID_LINE;
    endproperty
    a_line_first: assert property (p_line_first)
        else $error("line status not top priority");
    property p_none_id;
        @(posedge clk_sys) disable iff (reset)
        !irq_out |-> irq_ident_reg == 8'h01;
    endproperty
    a_none_id: assert property (p_none_id)
        else $error("idle ident wrong");
    property p_head_err_zero;
        @(posedge clk_sys) disable iff (reset)
        (rx_level == '0) |-> line_status_reg[4:2] == 3'b000;
    endproperty
    a_head_err_zero: assert property (p_head_err_zero)
        else $error("error bits set while empty");
    property p_flowpin;
        @(posedge clk_sys) disable iff (reset)
        $rose(s_q.fpin_s2[0]) && &s_q.warm && !ident_read |=> s_q.flowpin_irq;
    endproperty
    a_flowpin: assert property (p_flowpin)
        else $error("flow pin irq missed");
    property p_tx_dma_ready_n;
        @(posedge clk_sys) disable iff (reset)
        (!mode_block && !tx_empty) |-> tx_dma_ready_n;
    endproperty
    a_tx_dma_ready_n: assert property (p_tx_dma_ready_n)
        else $error("tx ready while loaded");
endmodule : ufc_ctrl

// *** ufc_remote.sv ***
// partner model: remote serial end that shifts out flow characters and data
`timescale 1ns/1ps
module ufc_remote (
    input  wire logic       clk_sys,
    input  wire logic       flow_load,
    input  wire logic [7:0] flow_char,
    input  wire logic [3:0] bit_time,
    input  wire logic       tx_allow,
    output logic            shifter_busy,
    output logic            shifter_done,
    output logic [7:0]      last_char,
    output logic [7:0]      prev_char,
    output int              loads
);
    int cnt;
    // ************************************
    // shifter: busy for bit_time+1 cycles per character
    // ************************************
    initial begin
        shifter_busy = 1'b0;
        shifter_done = 1'b0;
        last_char    = 8'h00;
        prev_char    = 8'h00;
        loads        = 0;
        cnt          = 0;
    end
    always @(posedge clk_sys) begin
        shifter_done <= 1'b0;
        if (flow_load) begin
            shifter_busy <= 1'b1;
            cnt          <= int'(bit_time);
            prev_char    <= last_char;
            last_char    <= flow_char;
            loads        <= loads + 1;
        end else if (tx_allow && !shifter_busy && !shifter_done) begin
            shifter_busy <= 1'b1;
            cnt          <= int'(bit_time);
        end else if (shifter_busy) begin
            if (cnt == 0) begin
                shifter_busy <= 1'b0;
                shifter_done <= 1'b1;
            end else begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : ufc_remote

// *** uart_flow_irq_dma_control_tb_top.sv ***
// testbench: flow, interrupt and dma control of one uart channel
`timescale 1ns/1ps
module uart_flow_irq_dma_control_tb_top;
    import ufc_pkg::*;
    logic clk_sys, reset, chars_we, scratch_we, divisor_we, rx_valid;
    logic rx_overrun, rx_timeout, rx_above_trig, rx_pop, tx_empty;
    logic tx_trig, tx_write, cts_pin, rts_pin, ident_read, lsr_read;
    logic msr_read, tx_allow, flow_load, irq_out, ser_out_idle, rts_n;
    logic dtr_n, rx_dma_ready_n, tx_dma_ready_n, shifter_busy, shifter_done;
    logic [7:0] irq_enable_reg, fifo_control_reg, enhanced_feature_reg;
    logic [7:0] flow_threshold_reg, scratch_in, rx_char, flow_char;
    logic [7:0] line_control_reg, line_status_reg, modem_status_reg;
    logic [7:0] irq_ident_reg, scratchpad_reg;
    logic [1:0]  word_len;
    logic [15:0] divisor_in, divisor_out;
    logic [6:0]  rx_level, rx_err_count;
    logic [3:0]  modem_pins, bit_time;
    ufc_chars_type chars_in, chars_out;
    ufc_err_type   rx_err, rx_head_err;
    int mismatches = 0;
    int tests_run = 0;
    int n;
    logic [7:0] efr_tab [4] = '{8'h08, 8'h04, 8'h08, 8'h0c};

    ufc_ctrl u_dut (.*);
    ufc_remote u_rem (.clk_sys(clk_sys), .flow_load(flow_load),
        .tx_allow(tx_allow),
        .flow_char(flow_char), .bit_time(bit_time),
        .shifter_busy(shifter_busy), .shifter_done(shifter_done),
        .last_char(), .prev_char(), .loads());

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ************************************
    // shared tasks
    // ************************************
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask : cyc
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    task automatic rx(input logic [7:0] c);
        rx_char = c;
        rx_valid = 1'b1;
        cyc(1);
        rx_valid = 1'b0;
        cyc(1);
    endtask : rx
    task automatic pl(input int w);
        case (w)
            0: ident_read = 1'b1;
            1: lsr_read = 1'b1;
            default: msr_read = 1'b1;
        endcase
        cyc(1);
        {ident_read, lsr_read, msr_read} = 3'b000;
        cyc(1);
    endtask : pl
    task automatic wait_loads(input int target);
        for (int k = 0; k < 200 && u_rem.loads < target; k++) cyc(1);
        chk(u_rem.loads >= target, 1'b1);
    endtask : wait_loads
    function automatic logic [7:0] msk(input logic [7:0] c, input int wl);
        return c & (8'hff >> (3 - wl));
    endfunction : msk
    function automatic logic [7:0] pick(input logic [7:0] a, b, e);
        return e[2] ? b : a;
    endfunction : pick
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
    // ************************************
    // main sequence
    // ************************************
    initial begin
        {reset, chars_we, scratch_we, divisor_we, rx_valid} = 5'h10;
        {rx_overrun, rx_timeout, rx_above_trig, rx_pop, tx_trig} = 5'h0;
        {tx_write, ident_read, lsr_read, msr_read} = 4'h0;
        {tx_empty, cts_pin, rts_pin} = 3'b111;
        {irq_enable_reg, fifo_control_reg} = 16'h0;
        {enhanced_feature_reg, flow_threshold_reg} = 16'h0;
        {scratch_in, rx_char, divisor_in, word_len} = 34'h0;
        {rx_level, rx_err_count, modem_pins, bit_time} = 22'h0;
        chars_in = '0;
        rx_err = '0;
        rx_head_err = '0;
        void'($urandom(57420));
        modem_pins = 4'ha;
        cyc(20);
        chk(irq_ident_reg, UFC_ID_NONE);
        chk(line_status_reg, UFC_LSR_RESET);
        chk(line_control_reg, UFC_LCR_RESET);
        chk(modem_status_reg[3:0], 4'h0);
        chk({ser_out_idle, rts_n, dtr_n, rx_dma_ready_n, tx_dma_ready_n},
            5'h1e);
        reset = 1'b0;
        cyc(4);
        chk(modem_status_reg, 8'ha0);
        chars_in = ufc_chars_type'($urandom);
        chars_in.resume_a = ~chars_in.pause_a;
        scratch_in = 8'($urandom);
        divisor_in = 16'($urandom);
        {chars_we, scratch_we, divisor_we} = 3'b111;
        cyc(1);
        {chars_we, scratch_we, divisor_we} = 3'b000;
        reset = 1'b1;
        cyc(3);
        reset = 1'b0;
        cyc(1);
        chk(chars_out, chars_in);
        chk({scratchpad_reg, divisor_out}, {scratch_in, divisor_in});
        $display("test reset done");
        // hardware flow bits 7:6 stay clear whenever software flow is on
        irq_enable_reg = 8'h20;
        enhanced_feature_reg = 8'h02;
        tx_empty = 1'b0;
        rx(chars_in.pause_a);
        cyc(2);
        chk(tx_allow, 1'b0);
        chk({irq_ident_reg, irq_out}, {UFC_ID_PAUSE, 1'b1});
        rx(chars_in.resume_a);
        chk({tx_allow, irq_ident_reg[5:0]},
            {1'b1, UFC_ID_NONE});
        enhanced_feature_reg = 8'h20;
        rx(chars_in.pause_b);
        chk({u_dut.s_q.halted, irq_ident_reg[5:0]},
            {1'b0, UFC_ID_PAUSE});
        pl(0);
        chk(irq_ident_reg, UFC_ID_NONE);
        $display("test receive flow done");
        irq_enable_reg = 8'h00;
        tx_empty = 1'b1;
        flow_threshold_reg = 8'h12;
        for (int i = 0; i < 4; i++) begin
            word_len = 2'(i);
            bit_time = 4'($urandom);
            enhanced_feature_reg = efr_tab[i];
            n = u_rem.loads;
            rx_level = 7'd9;
            wait_loads(n + (i == 3 ? 2 : 1));
            chk(u_rem.last_char, msk(pick(chars_in.pause_a,
                chars_in.pause_b, efr_tab[i]), i));
            if (i == 3) chk(u_rem.prev_char, msk(chars_in.pause_a, i));
            n = u_rem.loads;
            rx_level = 7'd4;
            wait_loads(n + (i == 3 ? 2 : 1));
            chk(u_rem.last_char, msk(pick(chars_in.resume_a,
                chars_in.resume_b, efr_tab[i]), i));
            cyc(20);
        end
        enhanced_feature_reg = 8'h00;
        $display("test transmit flow done");
        fifo_control_reg = 8'h08;
        rx_level = 7'd0;
        cyc(1);
        chk(tx_dma_ready_n, 1'b0);
        tx_empty = 1'b0;
        tx_write = 1'b1;
        cyc(1);
        tx_write = 1'b0;
        cyc(1);
        chk({tx_dma_ready_n, rx_dma_ready_n}, 2'b11);
        rx_level = 7'd1;
        cyc(2);
        chk(rx_dma_ready_n, 1'b0);
        $display("test dma done");
        fifo_control_reg = 8'h01;
        rx_level = 7'd0;
        rx_overrun = 1'b1;
        cyc(1);
        rx_overrun = 1'b0;
        cyc(1);
        chk(irq_out, 1'b0);
        pl(1);
        pl(0);
        pl(2);
        irq_enable_reg = 8'haf;
        cyc(1);
        chk(irq_ident_reg, UFC_ID_NONE);
        {rx_err_count, rx_level, rx_above_trig} = {7'd1, 7'd1, 1'b1};
        rx_head_err = 3'b101;
        cyc(2);
        chk({line_status_reg[7], line_status_reg[4:2]}, 4'hd);
        chk({irq_ident_reg, irq_out}, {UFC_ID_LINE, 1'b1});
        rx_err_count = 7'd0;
        cyc(2);
        chk(irq_ident_reg, UFC_ID_RXD);
        rx_overrun = 1'b1;
        cyc(1);
        rx_overrun = 1'b0;
        cyc(1);
        chk(irq_ident_reg, UFC_ID_LINE);
        pl(1);
        chk(irq_ident_reg, UFC_ID_RXD);
        {rx_above_trig, rx_timeout, rx_head_err} = 5'b01000;
        cyc(2);
        chk(irq_ident_reg, UFC_ID_TMO);
        {rx_timeout, rx_level} = 8'h0;
        cyc(2);
        chk({irq_ident_reg, line_status_reg[4:2]}, {UFC_ID_NONE, 3'b000});
        tx_trig = 1'b1;
        cyc(2);
        chk(irq_ident_reg, UFC_ID_THR);
        tx_trig = 1'b0;
        pl(0);
        chk(irq_ident_reg, UFC_ID_NONE);
        modem_pins = 4'h5;
        cyc(4);
        chk(irq_ident_reg, UFC_ID_MODEM);
        pl(2);
        chk(irq_ident_reg, UFC_ID_NONE);
        cts_pin = 1'b0;
        cyc(4);
        cts_pin = 1'b1;
        cyc(4);
        chk({irq_ident_reg, irq_out}, {UFC_ID_FLOWPIN, 1'b1});
        pl(0);
        chk({irq_ident_reg, irq_out}, {UFC_ID_NONE, 1'b0});
        $display("test interrupts done");
        stop_test();
    end
endmodule : uart_flow_irq_dma_control_tb_top
